// ==== verilog/scg_pkg.sv ====
// Package with constants and types of the system clock generator.
package scg_pkg;

   localparam longint REF_HZ         = 50_000_000;
   localparam longint FAST_OSC_HZ    = 8_000_000;
   localparam longint SLOW_OSC_HZ    = 32_000;
   localparam int     ACC_W          = 24;
   localparam longint ACC_SPAN       = longint'(1) << ACC_W;
   localparam logic [ACC_W-1:0] FAST_INC =
      ACC_W'((FAST_OSC_HZ * ACC_SPAN) / REF_HZ);
   localparam logic [ACC_W-1:0] SLOW_INC =
      ACC_W'((SLOW_OSC_HZ * ACC_SPAN) / REF_HZ);

   localparam logic [4:0] FAST_SETTLE_TICKS = 5'h10;
   localparam logic [1:0] SLOW_SETTLE_TICKS = 2'h2;

   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STAT_OFS   = 8'h04;
   localparam int     CKS_LSB        = 5;
   localparam int     SLOW_RDY_BIT   = 3;
   localparam int     FAST_RDY_BIT   = 2;
   localparam int     HL_BIT         = 0;
   localparam logic [2:0] CKS_RST    = 3'h0;
   localparam logic       HL_RST     = 1'b1;
   localparam logic [2:0] CKS_FIRST_FAST = 3'h2;
   localparam logic [2:0] LOG_OF_CODE0   = 3'h0;
   localparam logic [3:0] CODE_TO_LOG    = 4'h8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic sys;
      logic high_speed;
      logic time_base;
      logic watchdog;
   } scg_clk_en_t;

   typedef struct packed {
      logic        aw_got;
      logic        w_got;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic        wstrb0;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [2:0]  clock_select_field;
      logic        high_low_select;
      logic        cur_slow;
      logic [2:0]  cur_log;
      logic [5:0]  div_cnt;
      logic        fast_run;
      logic [4:0]  fast_settle;
      logic        fast_osc_ready_flag;
      logic [1:0]  slow_settle;
      logic        slow_osc_ready_flag;
      scg_clk_en_t clk_en;
   } scg_state_t;

endpackage : scg_pkg

// ==== verilog/scg_rc_osc.sv ====
// Internal RC oscillator modelled as a phase accumulator tick source.
`timescale 1ns/1ps
module scg_rc_osc
   import scg_pkg::*;
#(
   parameter logic [ACC_W-1:0] INC = FAST_INC
) (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic run_i,
   output logic      tick_o
);

   typedef struct packed {
      logic [ACC_W-1:0] acc;
      logic             tick;
   } scg_osc_state_t;

   scg_osc_state_t s_r;
   scg_osc_state_t s_nxt;
   logic [ACC_W:0] sum;

   // A stopped oscillator loses its phase, as a real RC cell would.
   always_comb begin
      s_nxt = s_r;
      sum   = {1'b0, s_r.acc} + {1'b0, INC};
      if (run_i) begin
         s_nxt.acc  = sum[ACC_W-1:0];
         s_nxt.tick = sum[ACC_W];
      end else begin
         s_nxt.acc  = '0;
         s_nxt.tick = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick_o = s_r.tick;

   AST_TICK_NEEDS_RUN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      tick_o |-> $past(run_i)) else $error("Tick from a stopped oscillator.");

endmodule : scg_rc_osc

// ==== verilog/scg_clock_gen.sv ====
// System clock generator: oscillators, source selector, register slave.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module scg_clock_gen
   import scg_pkg::*;
(
   input  wire logic        REF_CLK_I,
   input  wire logic        RST_B_I,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   output scg_clk_en_t      CLK_EN_O,
   output logic             FAST_OSC_RUN_O
);

   scg_state_t s_r;
   scg_state_t s_nxt;
   logic       fast_tick;
   logic       slow_tick;
   logic       tgt_slow;
   logic [2:0] tgt_log;
   logic       pending;
   logic       period_end;
   logic       target_ready;
   logic       commit;
   logic [5:0] div_mask;
   logic [31:0] ctrl_word;
   logic [31:0] stat_word;

   ////////////////////////////////////////////////////////////////////////
   // Oscillators.

   scg_rc_osc #(.INC(FAST_INC)) u_fast_rc_oscillator (
      .clk_i   (REF_CLK_I),
      .rst_b_i (RST_B_I),
      .run_i   (s_r.fast_run),
      .tick_o  (fast_tick)
   );

   // The slow cell never stops here: the watchdog depends on it.
   scg_rc_osc #(.INC(SLOW_INC)) u_slow_rc_oscillator (
      .clk_i   (REF_CLK_I),
      .rst_b_i (RST_B_I),
      .run_i   (1'b1),
      .tick_o  (slow_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Source decode and switch point.

   always_comb begin
      tgt_slow = !s_r.high_low_select &&
                 (s_r.clock_select_field < CKS_FIRST_FAST);
      if (s_r.high_low_select || tgt_slow) begin
         tgt_log = LOG_OF_CODE0;
      end else begin
         tgt_log = 3'(CODE_TO_LOG - {1'b0, s_r.clock_select_field});
      end
      div_mask = 6'((7'h01 << s_r.cur_log) - 7'h01);
      pending  = (tgt_slow != s_r.cur_slow) ||
                 (!tgt_slow && (tgt_log != s_r.cur_log));
      // A change only lands where the running period closes, so no
      // shortened pulse ever reaches the core.
      period_end = s_r.cur_slow ? slow_tick :
                   (fast_tick && (s_r.div_cnt == div_mask));
      target_ready = tgt_slow ? s_r.slow_osc_ready_flag :
                     s_r.fast_osc_ready_flag;
      commit = pending && period_end && target_ready;
   end

   always_comb begin
      ctrl_word = '0;
      ctrl_word[CKS_LSB+2:CKS_LSB] = s_r.clock_select_field;
      ctrl_word[SLOW_RDY_BIT]      = s_r.slow_osc_ready_flag;
      ctrl_word[FAST_RDY_BIT]      = s_r.fast_osc_ready_flag;
      ctrl_word[HL_BIT]            = s_r.high_low_select;
      stat_word = {26'h0000000, s_r.fast_run, pending,
                   s_r.cur_log, s_r.cur_slow};
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      s_nxt = s_r;
      // Register slave: address and data may come in either order.
      if (S_AXI_AWVALID && s_r.awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && s_r.wready) begin
         s_nxt.w_got  = 1'b1;
         s_nxt.wdata  = S_AXI_WDATA;
         s_nxt.wstrb0 = S_AXI_WSTRB[0];
      end
      if (s_r.bvalid && S_AXI_BREADY) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got  = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = RESP_OKAY;
         if (s_r.awaddr == CTRL_OFS) begin
            if (s_r.wstrb0) begin
               s_nxt.clock_select_field =
                  s_r.wdata[CKS_LSB+2:CKS_LSB];
               s_nxt.high_low_select = s_r.wdata[HL_BIT];
            end
         end else if (s_r.awaddr != STAT_OFS) begin
            s_nxt.bresp = RESP_SLVERR;
         end
      end
      s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
      s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;

      if (s_r.rvalid && S_AXI_RREADY) begin
         s_nxt.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = RESP_OKAY;
         if (S_AXI_ARADDR == CTRL_OFS) begin
            s_nxt.rdata = ctrl_word;
         end else if (S_AXI_ARADDR == STAT_OFS) begin
            s_nxt.rdata = stat_word;
         end else begin
            s_nxt.rdata = '0;
            s_nxt.rresp = RESP_SLVERR;
         end
      end
      s_nxt.arready = !s_nxt.rvalid;

      // Fast cell runs unless both the running and wanted source are slow.
      s_nxt.fast_run = !(tgt_slow && s_r.cur_slow);
      if (!s_r.fast_run) begin
         s_nxt.fast_settle         = '0;
         s_nxt.fast_osc_ready_flag = 1'b0;
      end else if (fast_tick && !s_r.fast_osc_ready_flag) begin
         s_nxt.fast_settle = s_r.fast_settle + 5'h01;
         if (s_r.fast_settle == FAST_SETTLE_TICKS - 5'h01) begin
            s_nxt.fast_osc_ready_flag = 1'b1;
         end
      end
      if (slow_tick && !s_r.slow_osc_ready_flag) begin
         s_nxt.slow_settle = s_r.slow_settle + 2'h1;
         if (s_r.slow_settle == SLOW_SETTLE_TICKS - 2'h1) begin
            s_nxt.slow_osc_ready_flag = 1'b1;
         end
      end

      if (!s_r.cur_slow && fast_tick) begin
         s_nxt.div_cnt = (s_r.div_cnt == div_mask) ? 6'h00 :
                         s_r.div_cnt + 6'h01;
      end
      if (commit) begin
         s_nxt.cur_slow = tgt_slow;
         s_nxt.cur_log  = tgt_log;
         s_nxt.div_cnt  = '0;
      end

      s_nxt.clk_en.sys        = period_end;
      s_nxt.clk_en.high_speed = fast_tick && s_r.fast_osc_ready_flag;
      s_nxt.clk_en.time_base  = slow_tick;
      s_nxt.clk_en.watchdog   = slow_tick;
   end

   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         s_r                    <= '0;
         s_r.clock_select_field <= CKS_RST;
         s_r.high_low_select    <= HL_RST;
         s_r.fast_run           <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign S_AXI_AWREADY  = s_r.awready;
   assign S_AXI_WREADY   = s_r.wready;
   assign S_AXI_BVALID   = s_r.bvalid;
   assign S_AXI_BRESP    = s_r.bresp;
   assign S_AXI_ARREADY  = s_r.arready;
   assign S_AXI_RVALID   = s_r.rvalid;
   assign S_AXI_RDATA    = s_r.rdata;
   assign S_AXI_RRESP    = s_r.rresp;
   assign CLK_EN_O       = s_r.clk_en;
   assign FAST_OSC_RUN_O = s_r.fast_run;

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_B_I);

   AST_FAST_RATE: assert property (
      fast_tick |=> !fast_tick) else $error("Fast ticks too close.");
   AST_SLOW_RATE: assert property (
      slow_tick |=> !slow_tick [*8]) else $error("Slow ticks too close.");
   AST_HS_SOURCE: assert property (
      CLK_EN_O.high_speed |-> $past(fast_tick))
      else $error("High speed pulse without fast tick.");
   // Decoded afresh from the register fields, not from the selector's own
   // target, so a wrong code table in the selector is caught.
   AST_DECODE: assert property (
      commit |=>
         (s_r.cur_slow == $past(!s_r.high_low_select &&
                                (s_r.clock_select_field <= 3'h1))) &&
         (s_r.cur_slow ||
          ($past(s_r.high_low_select) ? (s_r.cur_log == LOG_OF_CODE0) :
           (({1'b0, s_r.cur_log} +
             {1'b0, $past(s_r.clock_select_field)}) == CODE_TO_LOG))))
      else $error("Applied source differs from selection.");
   AST_DIV_MAX: assert property (
      !s_r.cur_slow |-> s_r.cur_log <= 3'h6)
      else $error("Division beyond 64.");
   AST_TIME_BASE: assert property (
      CLK_EN_O.time_base == $past(slow_tick))
      else $error("Time base clock not from slow oscillator.");
   AST_WATCHDOG: assert property (
      CLK_EN_O.watchdog == $past(slow_tick))
      else $error("Watchdog clock not from slow oscillator.");
   AST_FAST_STOP: assert property (
      (s_r.cur_slow && tgt_slow) |=> !FAST_OSC_RUN_O ##1 !fast_tick)
      else $error("Fast oscillator kept running on slow clock.");
   AST_READY_CLEAR: assert property (
      !s_r.fast_run |=> !s_r.fast_osc_ready_flag)
      else $error("Ready flag set while fast oscillator stopped.");
   AST_SWITCH_SAFE: assert property (
      $changed(s_r.cur_log) || $changed(s_r.cur_slow) |->
      $past(period_end) && $past(target_ready))
      else $error("Source switched mid period or to idle oscillator.");

endmodule : scg_clock_gen

// ==== verification/scg_clk_sink.sv ====
// Consumer model that measures the spacing of the clock enables.
`timescale 1ns/1ps
module scg_clk_sink
   import scg_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire scg_clk_en_t en_i,
   output logic [7:0]       hs_per_sys_o,
   output logic [7:0]       tb_per_sys_o,
   output logic [7:0]       tb_wd_err_o
);
   logic [7:0] hs_r;
   logic [7:0] tb_r;
   // A tick that lands with the sys pulse still closes the old period.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hs_r         <= 8'h00;
         tb_r         <= 8'h00;
         hs_per_sys_o <= 8'h00;
         tb_per_sys_o <= 8'h00;
         tb_wd_err_o  <= 8'h00;
      end else begin
         hs_r <= en_i.sys ? 8'h00 : hs_r + 8'(en_i.high_speed);
         tb_r <= en_i.sys ? 8'h00 : tb_r + 8'(en_i.time_base);
         if (en_i.sys) begin
            hs_per_sys_o <= hs_r + 8'(en_i.high_speed);
            tb_per_sys_o <= tb_r + 8'(en_i.time_base);
         end
         if (en_i.time_base != en_i.watchdog) begin
            tb_wd_err_o <= tb_wd_err_o + 8'h01;
         end
      end
   end
endmodule : scg_clk_sink

// ==== verification/testbench.sv ====
// Self-checking bench for the system clock generator.
`timescale 1ns/1ps
module testbench
   import scg_pkg::*;
;
   logic        clk;
   logic        rst_b;
   logic [7:0]  awaddr;
   logic [7:0]  araddr;
   logic        awvalid;
   logic        wvalid;
   logic        bready;
   logic        arvalid;
   logic        rready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        awready;
   logic        wready;
   logic        bvalid;
   logic        arready;
   logic        rvalid;
   logic [1:0]  bresp;
   logic [1:0]  rresp;
   logic [31:0] rdata;
   scg_clk_en_t en;
   logic        run;
   logic [7:0]  hps;
   logic [7:0]  tps;
   logic [7:0]  twe;
   logic [31:0] d;
   logic [1:0]  r;
   int          err_count;
   int          checked;

   scg_clock_gen dut (.REF_CLK_I(clk), .RST_B_I(rst_b),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .CLK_EN_O(en), .FAST_OSC_RUN_O(run));

   scg_clk_sink sink (.clk_i(clk), .rst_b_i(rst_b), .en_i(en),
      .hs_per_sys_o(hps), .tb_per_sys_o(tps), .tb_wd_err_o(twe));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [33:0] e,
                      input logic [33:0] s);
      checked++;
      if (s !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, s);
         err_count++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk);
         if (aw && awready === 1'b1) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready === 1'b1) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end while (aw || w);
      while (bvalid !== 1'b1) @(posedge clk);
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   task automatic finish_test();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      finish_test();
   end

   initial begin
      rst_b = 1'b0;
      {awaddr, araddr, awvalid, wvalid, bready} = '0;
      {arvalid, rready, wdata} = '0;
      wstrb = 4'hF;
      err_count = 0;
      checked = 0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      rd(CTRL_OFS);
      chk("ctrl_reset", {RESP_OKAY, 32'h01}, {r, d});
      repeat (300) @(posedge clk);
      rd(CTRL_OFS);
      chk("ctrl_fast_ready", {RESP_OKAY, 32'h05}, {r, d});
      chk("fast_undivided", 34'h1, 34'(hps));
      wr(STAT_OFS, 32'hFF);
      chk("stat_write", 34'(RESP_OKAY), 34'(r));
      rd(STAT_OFS);
      chk("stat_fast", {RESP_OKAY, 32'h20}, {r, d});
      // Each code is held long enough for two divide-by-64 periods.
      for (int c = 2; c < 8; c++) begin
         wr(CTRL_OFS, 32'(c) << CKS_LSB);
         repeat (1500) @(posedge clk);
         chk("fast_div", 34'(1) << (8 - c), 34'(hps));
      end
      wr(8'h0C, 32'h01);
      chk("bad_write", 34'(RESP_SLVERR), 34'(r));
      rd(8'h08);
      chk("bad_read", {RESP_SLVERR, 32'h0}, {r, d});
      for (int c = 0; c < 2; c++) begin
         wr(CTRL_OFS, 32'(c) << CKS_LSB);
         repeat (7000) @(posedge clk);
         chk("slow_sys", 34'h1, 34'(tps));
         chk("fast_stopped", 34'h0, 34'(run));
         rd(STAT_OFS);
         chk("stat_slow", 34'h01, 34'(d & 32'h21));
         rd(CTRL_OFS);
         chk("ctrl_slow", 34'((c << CKS_LSB) | 8), 34'(d));
      end
      // A cleared lane-0 strobe must leave the control word alone.
      wstrb <= 4'hE;
      wr(CTRL_OFS, 32'h01);
      wstrb <= 4'hF;
      chk("strobe_write", 34'(RESP_OKAY), 34'(r));
      rd(CTRL_OFS);
      chk("ctrl_strobe", {RESP_OKAY, 32'h28}, {r, d});
      wr(CTRL_OFS, 32'h01);
      // The fast cell needs its settle ticks, so the switch is still held.
      rd(STAT_OFS);
      chk("stat_pending", {RESP_OKAY, 32'h31}, {r, d});
      chk("fast_restart", 34'h1, 34'(run));
      // The switch back lands only at a slow period end, so wait past one.
      repeat (2000) @(posedge clk);
      chk("fast_back", 34'h1, 34'(hps));
      chk("tb_eq_wd", 34'h0, 34'(twe));
      finish_test();
   end
endmodule : testbench
